/* File: logic/apc_host.sv */
// host end: axi4-lite registers drive pins, recovery timers gate captured words
// assumes an axi4-lite master on clk
`timescale 1ns/100ps
module apc_host #(
    parameter int unsigned PD_REC    = apc_pkg::PD_REC_CYC,
    parameter int unsigned LONG_REC  = apc_pkg::LONG_REC_CYC,
    parameter int unsigned SHORT_REC = apc_pkg::SHORT_REC_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // axi4-lite slave
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // link
    apc_link_if.host         lnk
);
    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic        aw_q, w_q, bv_q;
    logic [7:0]  awa_q;
    logic [31:0] wd_q;
    logic [2:0]  pulse_q;
    wire         do_wr  = aw_q & w_q & ~bv_q;
    wire         wr_ok  = awa_q == apc_pkg::REG_CTRL;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_q    <= 1'b0;
            w_q     <= 1'b0;
            bv_q    <= 1'b0;
            awa_q   <= '0;
            wd_q    <= '0;
            s_bresp <= apc_pkg::RESP_OKAY;
            ctrl_q  <= apc_pkg::CTRL_RESET;
            pulse_q <= '0;
        end else begin
            if (s_awvalid && !aw_q) begin
                aw_q  <= 1'b1;
                awa_q <= s_awaddr;
            end
            if (s_wvalid && !w_q) begin
                w_q  <= 1'b1;
                wd_q <= s_wdata;
            end
            if (pulse_q != '0) begin
                pulse_q <= pulse_q - 3'h1;
            end
            if (do_wr) begin
                aw_q    <= 1'b0;
                w_q     <= 1'b0;
                bv_q    <= 1'b1;
                s_bresp <= wr_ok ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
                if (wr_ok && s_wstrb[0]) begin
                    ctrl_q[7:0] <= wd_q[7:0];
                    if (wd_q[apc_pkg::CTRL_RST_BIT]) begin
                        pulse_q <= 3'(apc_pkg::SEL_PULSE_CYC);
                    end
                end
            end else if (bv_q && s_bready) begin
                bv_q <= 1'b0;
            end
        end
    end
    assign s_awready = ~aw_q;
    assign s_wready  = ~w_q;
    assign s_bvalid  = bv_q;

    // ------------------------------------------------------------
    // recovery timers
    // ------------------------------------------------------------
    logic [19:0] rec_q;
    logic [7:0]  gap_q;
    logic        pd_q, st_q;
    wire         pd_pin   = ctrl_q[apc_pkg::CTRL_PD_BIT];
    wire         run_pin  = ctrl_q[apc_pkg::CTRL_CLKRUN_BIT];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rec_q <= '0;
            gap_q <= '0;
            pd_q  <= 1'b0;
            st_q  <= 1'b0;
        end else begin
            pd_q <= pd_pin;
            st_q <= lnk.stopped;
            if (!run_pin) begin
                if (gap_q != 8'hFF) begin
                    gap_q <= gap_q + 8'h1;
                end
            end else begin
                gap_q <= '0;
            end
            if (pd_q && !pd_pin) begin
                rec_q <= 20'(PD_REC);
            end else if (st_q && !lnk.stopped) begin
                rec_q <= 20'(LONG_REC);
            end else if (run_pin && gap_q != '0 && rec_q < 20'(SHORT_REC)) begin
                rec_q <= 20'(SHORT_REC);
            end else if (rec_q != '0) begin
                rec_q <= rec_q - 20'h1;
            end
        end
    end
    wire good = lnk.samp_valid & (rec_q == '0) & ~pd_pin;

    // ------------------------------------------------------------
    // capture and read channel
    // ------------------------------------------------------------
    logic [31:0] samp_q, rd_q;
    logic        rv_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            samp_q  <= '0;
            rd_q    <= '0;
            rv_q    <= 1'b0;
            s_rresp <= apc_pkg::RESP_OKAY;
        end else begin
            if (good) begin
                samp_q <= {1'b1, 7'h00, lnk.over_range_flag_b, lnk.over_range_flag_a,
                           2'h0, lnk.data_b, lnk.data_a};
            end
            if (s_arvalid && !rv_q) begin
                rv_q    <= 1'b1;
                s_rresp <= apc_pkg::RESP_OKAY;
                case (s_araddr)
                    apc_pkg::REG_CTRL:   rd_q <= ctrl_q;
                    apc_pkg::REG_STATUS: rd_q <= {29'h0, rec_q != '0, lnk.stopped, good};
                    apc_pkg::REG_SAMPLE: rd_q <= samp_q;
                    default: begin
                        rd_q    <= '0;
                        s_rresp <= apc_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (rv_q && s_rready) begin
                rv_q <= 1'b0;
            end
        end
    end
    assign s_arready = ~rv_q;
    assign s_rvalid  = rv_q;
    assign s_rdata   = rd_q;

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign lnk.sel_n                 = ~(pulse_q != '0);
    assign lnk.sel_used              = ctrl_q[apc_pkg::CTRL_SPEN_BIT];
    assign lnk.top_bit_invert_select = ctrl_q[apc_pkg::CTRL_FMT_BIT];
    assign lnk.standby_power_down    = pd_pin;
    assign lnk.clk_run               = run_pin;
    assign lnk.chan_pd_we            = do_wr & wr_ok;
    assign lnk.chan_pd_val           = wd_q[apc_pkg::CTRL_CHPD_LSB +: 2];
endmodule

/* File: logic/apc_pkg.sv */
// package for the converter control link: pin timing, codes and host registers
// assumes a single 125 MHz clock shared by both ends
package apc_pkg;
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned DATA_W         = 10;
    // ------------------------------------------------------------
    // pipeline and timing
    // ------------------------------------------------------------
    localparam int unsigned PIPE_DEPTH     = 6;
    localparam int unsigned STOP_NS        = 250;
    localparam int unsigned STOP_CYC       = (STOP_NS * CLK_MHZ) / 1000;
    localparam int unsigned MIN_RATE_KHZ   = 2000;
    localparam int unsigned SLOW_CYC       = (CLK_MHZ * 1000) / MIN_RATE_KHZ;
    localparam int unsigned PD_REC_US      = 500;
    localparam int unsigned PD_REC_CYC     = PD_REC_US * CLK_MHZ;
    localparam int unsigned LONG_REC_US    = 100;
    localparam int unsigned LONG_REC_CYC   = LONG_REC_US * CLK_MHZ;
    localparam int unsigned SHORT_REC_US   = 10;
    localparam int unsigned SHORT_REC_CYC  = SHORT_REC_US * CLK_MHZ;
    // ------------------------------------------------------------
    // output coding
    // ------------------------------------------------------------
    localparam logic [9:0]  CODE_POS_FS    = 10'h3FF;
    localparam logic [9:0]  CODE_MID       = 10'h200;
    localparam logic [9:0]  CODE_NEG_FS    = 10'h000;
    localparam logic [1:0]  CHAN_PD_RESET  = 2'h0;
    // ------------------------------------------------------------
    // host registers (byte addresses on axi4-lite, one word apart)
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_SAMPLE     = 8'h08;
    localparam int unsigned CTRL_PD_BIT    = 0;
    localparam int unsigned CTRL_FMT_BIT   = 1;
    localparam int unsigned CTRL_SPEN_BIT  = 2;
    localparam int unsigned CTRL_RST_BIT   = 3;
    localparam int unsigned CTRL_CHPD_LSB  = 4;
    localparam int unsigned CTRL_CLKRUN_BIT = 6;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0040;
    localparam int unsigned SEL_PULSE_CYC  = 4;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

/* File: logic/apc_link_if.sv */
// pin link between converter control end and host end
// assumes both ends on the same clock
`timescale 1ns/100ps
interface apc_link_if;
    logic       sel_n;
    logic       sel_used;
    logic       top_bit_invert_select;
    logic       standby_power_down;
    logic       clk_run;
    logic       chan_pd_we;
    logic [1:0] chan_pd_val;
    logic [9:0] data_a;
    logic [9:0] data_b;
    logic       over_range_flag_a;
    logic       over_range_flag_b;
    logic       samp_valid;
    logic       stopped;
    modport dev  (input sel_n, sel_used, top_bit_invert_select, standby_power_down, clk_run,
                  chan_pd_we, chan_pd_val,
                  output data_a, data_b, over_range_flag_a, over_range_flag_b, samp_valid,
                  stopped);
    modport host (output sel_n, sel_used, top_bit_invert_select, standby_power_down, clk_run,
                  chan_pd_we, chan_pd_val,
                  input data_a, data_b, over_range_flag_a, over_range_flag_b, samp_valid,
                  stopped);
endinterface

/* File: logic/apc_device.sv */
// converter control end: select/reset, coding, power-down, clock-stop monitor
// assumes raw samples arrive on the user port once per sample-clock tick
//
// Behaviour
// - serial port off while select held low
// - host pulses select low once after power-up; code pulses only when a write sets CTRL_RST_BIT
// - select pulse clears programmable registers to zero
// - format low gives offset binary
// - format high inverts top bit only
// - power-down pin high stops everything
// - undriven power-down pin means normal operation
// - host waits 500 us after power-down exit
// - clock stop over 250 ns forces partial power-down
// - host waits 100 us after long stop
// - host waits 10 us after short stop
// - channels powered down singly via registers
// - undriven format pin means offset binary
// - word and over-range flag six ticks late; code gives seven (six pipeline stages plus output register)
`timescale 1ns/100ps
module apc_device #(
    parameter int unsigned PIPE = apc_pkg::PIPE_DEPTH
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // link
    apc_link_if.dev         lnk,
    // raw analog samples, signed offset from mid-scale
    input  wire logic [9:0] raw_a,
    input  wire logic [9:0] raw_b,
    input  wire logic       raw_ovr_a,
    input  wire logic       raw_ovr_b,
    // state
    output logic            full_pd,
    output logic            part_pd,
    output logic [1:0]      chan_pd
);
    // ------------------------------------------------------------
    // select/reset and registers
    // ------------------------------------------------------------
    logic       spen_q;
    logic       sel_q;
    logic [1:0] chan_pd_q;
    wire        sel_fall = sel_q & ~lnk.sel_n;
    wire        port_on  = lnk.sel_used;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_q     <= 1'b1;
            spen_q    <= 1'b0;
            chan_pd_q <= apc_pkg::CHAN_PD_RESET;
        end else begin
            sel_q  <= lnk.sel_n;
            spen_q <= port_on;
            if (!port_on || sel_fall) begin
                chan_pd_q <= apc_pkg::CHAN_PD_RESET;
            end else if (lnk.chan_pd_we && spen_q) begin
                chan_pd_q <= lnk.chan_pd_val;
            end
        end
    end

    // ------------------------------------------------------------
    // clock-stop monitor
    // ------------------------------------------------------------
    localparam int unsigned GW = 8;
    logic [GW-1:0] gap_q;
    logic          part_q;
    wire           tick   = lnk.clk_run & ~lnk.standby_power_down;
    wire           slow   = gap_q >= GW'(apc_pkg::SLOW_CYC);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_q  <= '0;
            part_q <= 1'b0;
        end else begin
            if (lnk.clk_run) begin
                gap_q <= '0;
            end else if (!slow) begin
                gap_q <= gap_q + GW'(1);
            end
            if (lnk.clk_run) begin
                part_q <= 1'b0;
            end else if (gap_q >= GW'(apc_pkg::STOP_CYC)) begin
                part_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // coding and pipeline
    // ------------------------------------------------------------
    function automatic logic [9:0] code(input logic [9:0] s, input logic twos_complement_format);
        logic [9:0] ob;
        ob   = s ^ apc_pkg::CODE_MID;
        code = twos_complement_format ? {~ob[9], ob[8:0]} : ob;
    endfunction
    logic [9:0] pa_q [PIPE];
    logic [9:0] pb_q [PIPE];
    logic [PIPE-1:0] oa_q, ob_q, v_q;
    wire active = tick & ~part_q;
    wire fmt    = lnk.top_bit_invert_select;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PIPE; i++) begin
                pa_q[i] <= '0;
                pb_q[i] <= '0;
            end
            oa_q <= '0;
            ob_q <= '0;
            v_q  <= '0;
        end else if (lnk.standby_power_down) begin
            v_q <= '0;
        end else if (active) begin
            pa_q[0] <= chan_pd_q[0] ? '0 : code(raw_a, fmt);
            pb_q[0] <= chan_pd_q[1] ? '0 : code(raw_b, fmt);
            oa_q[0] <= raw_ovr_a & ~chan_pd_q[0];
            ob_q[0] <= raw_ovr_b & ~chan_pd_q[1];
            v_q[0]  <= 1'b1;
            for (int i = 1; i < PIPE; i++) begin
                pa_q[i] <= pa_q[i-1];
                pb_q[i] <= pb_q[i-1];
            end
            oa_q <= {oa_q[PIPE-2:0], raw_ovr_a & ~chan_pd_q[0]};
            ob_q <= {ob_q[PIPE-2:0], raw_ovr_b & ~chan_pd_q[1]};
            v_q  <= {v_q[PIPE-2:0], 1'b1};
        end
    end
    logic [9:0] da_q, db_q;
    logic       ova_q, ovb_q, sv_q, st_q, fpd_q, ppd_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            da_q  <= '0;
            db_q  <= '0;
            ova_q <= 1'b0;
            ovb_q <= 1'b0;
            sv_q  <= 1'b0;
            st_q  <= 1'b0;
            fpd_q <= 1'b0;
            ppd_q <= 1'b0;
        end else begin
            da_q  <= pa_q[PIPE-1];
            db_q  <= pb_q[PIPE-1];
            ova_q <= oa_q[PIPE-1];
            ovb_q <= ob_q[PIPE-1];
            sv_q  <= active & v_q[PIPE-1];
            st_q  <= part_q;
            fpd_q <= lnk.standby_power_down;
            ppd_q <= part_q & ~lnk.standby_power_down;
        end
    end
    assign lnk.data_a            = da_q;
    assign lnk.data_b            = db_q;
    assign lnk.over_range_flag_a = ova_q;
    assign lnk.over_range_flag_b = ovb_q;
    assign lnk.samp_valid        = sv_q;
    assign lnk.stopped           = st_q;
    assign full_pd               = fpd_q;
    assign part_pd               = ppd_q;
    assign chan_pd               = chan_pd_q;
endmodule

/* File: verification/apc_link_sva.sv */
// checker for the pin link between host end and converter end
// assumes one clock, reset asynchronous and active high
`timescale 1ns/100ps
module apc_link_sva (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // host to converter
    input  wire logic       sel_n,
    input  wire logic       sel_used,
    input  wire logic       clk_run,
    input  wire logic       standby_power_down,
    input  wire logic       chan_pd_we,
    // converter to host
    input  wire logic [9:0] data_a,
    input  wire logic       over_range_flag_a,
    input  wire logic       samp_valid,
    input  wire logic       stopped
);
    // ------------------------------------------------------------
    // cycles the sample clock has stood still, saturating
    // ------------------------------------------------------------
    logic [5:0] low_q;
    logic [5:0] low_d;
    assign low_d = clk_run ? 6'h00 : ((low_q == 6'h3F) ? low_q : low_q + 6'h01);
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            low_q <= 6'h00;
        else
            low_q <= low_d;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_ticking;
        (clk_run && !standby_power_down && !stopped)[*8];
    endsequence
    sequence s_sel_low;
        !sel_n[*4] ##1 sel_n;
    endsequence
    a_reset_idle_pins: assert property (
        $fell(rst) |-> sel_n && clk_run && !standby_power_down)
        else $error("pins not idle after reset");
    a_sel_pulse_len: assert property (
        $fell(sel_n) && sel_used |-> s_sel_low)
        else $error("select pulse length wrong");
    a_chan_we_single: assert property (
        chan_pd_we |=> !chan_pd_we)
        else $error("channel write not a single pulse");
    a_stop_partial_pd: assert property (
        low_q > 6'h22 |-> stopped || standby_power_down)
        else $error("stopped clock not flagged");
    a_run_clears_stop: assert property (
        clk_run[*8] |-> !stopped)
        else $error("stop flag held with clock running");
    a_word_flow: assert property (
        s_ticking |-> samp_valid)
        else $error("no word after pipeline filled");
    a_hold_no_tick: assert property (
        !clk_run && low_q < 6'h14 && !standby_power_down
        |-> ##2 $stable(data_a) && $stable(over_range_flag_a))
        else $error("word changed without a tick");
    a_pd_no_word: assert property (
        standby_power_down[*3] |-> !samp_valid)
        else $error("word valid in power-down");
endmodule

/* File: verification/tb_adc_power_coding_control.sv */
// testbench joining host end and converter end over the pin link
// assumes axi4-lite host registers as laid out in the package
`timescale 1ns/100ps
module tb_adc_power_coding_control;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, rr, chan_pd;
    logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready, full_pd, part_pd;
    logic [9:0]  raw_a, raw_b;
    logic        raw_ovr_a, raw_ovr_b;
    int          bad_count = 0;
    int          compares = 0;
    int          n;
    // format, raw sample, expected word
    localparam logic [20:0] ROWS [10] = '{
        {1'h0, 10'h1FF, 10'h3FF}, {1'h0, 10'h100, 10'h300}, {1'h0, 10'h000, 10'h200},
        {1'h0, 10'h300, 10'h100}, {1'h0, 10'h200, 10'h000}, {1'h1, 10'h1FF, 10'h1FF},
        {1'h1, 10'h100, 10'h100}, {1'h1, 10'h000, 10'h000}, {1'h1, 10'h300, 10'h300},
        {1'h1, 10'h200, 10'h200}};

    always #4 clk = ~clk;

    apc_link_if apc_link_if_i ();
    apc_device apc_device_i (.clk(clk), .rst(rst), .lnk(apc_link_if_i.dev), .raw_a(raw_a),
        .raw_b(raw_b), .raw_ovr_a(raw_ovr_a), .raw_ovr_b(raw_ovr_b), .full_pd(full_pd),
        .part_pd(part_pd), .chan_pd(chan_pd));
    apc_host #(.PD_REC(20), .LONG_REC(10), .SHORT_REC(5)) apc_host_i (.clk(clk), .rst(rst),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .lnk(apc_link_if_i.host));
    apc_link_sva apc_link_sva_i (.clk(clk), .rst(rst), .sel_n(apc_link_if_i.sel_n),
        .sel_used(apc_link_if_i.sel_used), .clk_run(apc_link_if_i.clk_run),
        .standby_power_down(apc_link_if_i.standby_power_down),
        .chan_pd_we(apc_link_if_i.chan_pd_we), .data_a(apc_link_if_i.data_a),
        .over_range_flag_a(apc_link_if_i.over_range_flag_a),
        .samp_valid(apc_link_if_i.samp_valid), .stopped(apc_link_if_i.stopped));

    // ------------------------------------------------------------
    // compare, bus and closing tasks
    // ------------------------------------------------------------
    task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= 4'hF;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_awready)
                s_awvalid <= 1'b0;
            if (s_wready)
                s_wvalid <= 1'b0;
        end while (!s_bvalid);
        rr = s_bresp;
        s_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_arready)
                s_arvalid <= 1'b0;
        end while (!s_rvalid);
        rd = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= 5'h00;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} <= '0;
        {raw_a, raw_b, raw_ovr_a, raw_ovr_b} <= '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_bit("standby", 1'b0, apc_link_if_i.standby_power_down);
        chk_bit("format", 1'b0, apc_link_if_i.top_bit_invert_select);
        chk_bus("chan_pd", 32'h0, 32'(chan_pd));
        axi_rd(apc_pkg::REG_CTRL);
        chk_bus("ctrl", apc_pkg::CTRL_RESET, rd);
        for (int i = 0; i < 10; i++) begin
            axi_wr(apc_pkg::REG_CTRL, {25'h0, 1'b1, 4'h0, ROWS[i][20], 1'b0});
            raw_a <= ROWS[i][19:10];
            raw_b <= ROWS[i][19:10];
            raw_ovr_a <= i[0];
            raw_ovr_b <= !i[0];
            repeat (10) @(posedge clk);
            chk_bus("data_a", 32'(ROWS[i][9:0]), 32'(apc_link_if_i.data_a));
            chk_bus("data_b", 32'(ROWS[i][9:0]), 32'(apc_link_if_i.data_b));
            chk_bit("ovr_a", i[0], apc_link_if_i.over_range_flag_a);
            chk_bit("ovr_b", !i[0], apc_link_if_i.over_range_flag_b);
            axi_rd(apc_pkg::REG_SAMPLE);
            chk_bus("sample", {1'b1, 7'h00, !i[0], i[0], 2'h0, {2{ROWS[i][9:0]}}}, rd);
        end
        axi_wr(apc_pkg::REG_CTRL, 32'h40);
        repeat (10) @(posedge clk);
        raw_a <= 10'h155;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (apc_link_if_i.data_a !== 10'h355 && n < 20);
        chk_bus("latency", 32'h7, 32'(n));
        axi_wr(apc_pkg::REG_CTRL, 32'h41);
        repeat (4) @(posedge clk);
        chk_bit("full_pd", 1'b1, full_pd);
        chk_bit("samp_valid", 1'b0, apc_link_if_i.samp_valid);
        axi_wr(apc_pkg::REG_CTRL, 32'h40);
        axi_rd(apc_pkg::REG_STATUS);
        chk_bus("status", 32'h4, {29'h0, rd[2:0]});
        repeat (30) @(posedge clk);
        axi_rd(apc_pkg::REG_STATUS);
        chk_bus("status", 32'h1, {29'h0, rd[2:0]});
        axi_wr(apc_pkg::REG_CTRL, 32'h00);
        repeat (40) @(posedge clk);
        chk_bit("part_pd", 1'b1, part_pd);
        chk_bit("stopped", 1'b1, apc_link_if_i.stopped);
        axi_wr(apc_pkg::REG_CTRL, 32'h40);
        repeat (2) @(posedge clk);
        axi_rd(apc_pkg::REG_STATUS);
        chk_bit("recovering", 1'b1, rd[2]);
        repeat (4) @(posedge clk);
        axi_rd(apc_pkg::REG_STATUS);
        chk_bit("recovering", 1'b1, rd[2]);
        repeat (30) @(posedge clk);
        axi_wr(apc_pkg::REG_CTRL, 32'h00);
        repeat (10) @(posedge clk);
        axi_wr(apc_pkg::REG_CTRL, 32'h40);
        axi_rd(apc_pkg::REG_STATUS);
        chk_bit("recovering", 1'b1, rd[2]);
        repeat (8) @(posedge clk);
        axi_rd(apc_pkg::REG_STATUS);
        chk_bit("recovering", 1'b0, rd[2]);
        axi_wr(apc_pkg::REG_CTRL, 32'h50);
        repeat (4) @(posedge clk);
        chk_bus("chan_pd", 32'h0, 32'(chan_pd));
        axi_wr(apc_pkg::REG_CTRL, 32'h44);
        repeat (8) @(posedge clk);
        axi_wr(apc_pkg::REG_CTRL, 32'h64);
        repeat (8) @(posedge clk);
        chk_bus("chan_pd", 32'h2, 32'(chan_pd));
        chk_bus("data_b", 32'h0, 32'(apc_link_if_i.data_b));
        chk_bus("data_a", 32'h355, 32'(apc_link_if_i.data_a));
        axi_wr(apc_pkg::REG_CTRL, 32'h6C);
        repeat (8) @(posedge clk);
        chk_bus("chan_pd", 32'h0, 32'(chan_pd));
        axi_wr(8'h0C, 32'h1);
        chk_bus("bresp", 32'(apc_pkg::RESP_SLVERR), 32'(rr));
        axi_rd(8'h0C);
        chk_bus("rresp", 32'(apc_pkg::RESP_SLVERR), 32'(rr));
        chk_bus("rdata", 32'h0, rd);
        print_verdict();
    end
endmodule
